//--- dv/configurable_gpio_io_logic_tb.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// pin logic bench
// ----------------------------------------------------------------
module configurable_gpio_io_logic_tb;
	import gpio_pkg::*;
	// drv is {launch, core_oe, ext_drive, ext_val}, exp is {out, oe_n, up, down, alt}
	typedef struct packed {logic [13:0] ctrl; logic [3:0] drv; logic [4:0] exp; logic rx;} row_t;
	logic      clk = 1'b0;
	logic      resetn = 1'b0;
	reg_addr_t reg_addr = 8'h00;
	reg_word_t reg_wdata = 32'h0000_0000;
	logic      reg_wr = 1'b0;
	logic      reg_rd = 1'b0;
	reg_word_t reg_rdata;
	logic      config_active = 1'b0;
	logic      receive_clock = 1'b0;
	logic      transmit_clock = 1'b0;
	logic      core_clock_tree = 1'b0;
	logic      rise_launch_bit = 1'b0;
	logic      fall_launch_bit = 1'b0;
	logic      core_oe = 1'b0;
	logic      ext_drive = 1'b0;
	logic      ext_val = 1'b0;
	logic      rise_sample_bit, fall_sample_bit, alternate_input_route, pad_in;
	logic      pad_out, pad_oe_n, pad_pull_up, pad_pull_down;
	reg_word_t d;
	int        err_count = 0;
	int        n_checks = 0;
	row_t      rows [10] = '{
		{14'h0000, 4'b0000, 5'b01101, 1'b0}, {14'h2000, 4'b0000, 5'b01010, 1'b0},
		{14'h0001, 4'b0011, 5'b01101, 1'b1}, {14'h2001, 4'b0010, 5'b01010, 1'b1},
		{14'h0002, 4'b1000, 5'b10001, 1'b0}, {14'h0202, 4'b1000, 5'b00000, 1'b0},
		{14'h0003, 4'b0100, 5'b00000, 1'b1}, {14'h0203, 4'b0100, 5'b10001, 1'b1},
		{14'h0003, 4'b1011, 5'b01101, 1'b1}, {14'h0005, 4'b1100, 5'b01101, 1'b0}};

	gpio_io_logic DUT (.clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.config_active, .receive_clock, .transmit_clock, .core_clock_tree, .rise_launch_bit,
		.fall_launch_bit, .core_oe, .rise_sample_bit, .fall_sample_bit, .alternate_input_route,
		.pad_in, .pad_out, .pad_oe_n, .pad_pull_up, .pad_pull_down);
	pad_model u_pad (.clk, .pad_out, .pad_oe_n, .pad_pull_up, .pad_pull_down, .ext_drive,
		.ext_val, .pad_in);

	always #20 clk = ~clk;

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask : tick

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic wr(input reg_addr_t a, input reg_word_t v);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr

	// read data stand only in the cycle after the strobe; take them mid-cycle
	task automatic rd(input reg_addr_t a, output reg_word_t v);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(negedge clk);
		v = reg_rdata;
	endtask : rd

	// core clocks as {receive, transmit, tree}; each level held four cycles so the
	// sampled edge is surely seen before the next one
	task automatic step(input logic [2:0] c, input logic v);
		{receive_clock, transmit_clock, core_clock_tree} <= c;
		ext_val <= v;
		tick(4);
	endtask : step

	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : finish_test

	initial begin
		repeat (3000) @(posedge clk);
		err_count++;
		finish_test();
	end

	initial begin
		tick(10);
		check("reset", {27'h0, pad_out, pad_oe_n, pad_pull_up, pad_pull_down, pad_in}, 32'hd);
		resetn <= 1'b1;
		// plain mode table, all paths unregistered
		foreach (rows[i]) begin
			wr(8'h00, {18'h0, rows[i].ctrl});
			{rise_launch_bit, core_oe, ext_drive, ext_val} <= rows[i].drv;
			tick(2);
			check("pins", {pad_out, pad_oe_n, pad_pull_up, pad_pull_down, alternate_input_route}, 32'(rows[i].exp));
			if (rows[i].rx) check("rx", {fall_sample_bit, rise_sample_bit}, 32'(rows[i].exp[0]));
		end
		core_oe <= 1'b0;
		ext_drive <= 1'b1;
		// registered input, rising then falling edge
		wr(8'h00, 32'h0000_0009);
		step(3'b000, 1'b1);
		step(3'b100, 1'b1);
		step(3'b100, 1'b0);
		check("rx_hold", 32'(rise_sample_bit), 32'h1);
		step(3'b000, 1'b0);
		check("rx_rise_only", 32'(rise_sample_bit), 32'h1);
		wr(8'h00, 32'h0000_0019);
		step(3'b100, 1'b0);
		check("rx_fall_wait", 32'(rise_sample_bit), 32'h1);
		step(3'b000, 1'b0);
		check("rx_fall", 32'(rise_sample_bit), 32'h0);
		// double rate input, then the resynchronised variant
		wr(8'h00, 32'h0000_0401);
		step(3'b100, 1'b1);
		step(3'b000, 1'b0);
		check("ddr_in_a", {fall_sample_bit, rise_sample_bit}, 32'h1);
		step(3'b100, 1'b0);
		step(3'b000, 1'b1);
		check("ddr_in_b", {fall_sample_bit, rise_sample_bit}, 32'h2);
		wr(8'h00, 32'h0000_0c01);
		step(3'b100, 1'b1);
		step(3'b000, 1'b0);
		check("resync_a", {fall_sample_bit, rise_sample_bit}, 32'h3);
		step(3'b100, 1'b0);
		check("resync_b", {fall_sample_bit, rise_sample_bit}, 32'h0);
		// double rate output
		ext_drive <= 1'b0;
		wr(8'h00, 32'h0000_1002);
		{rise_launch_bit, fall_launch_bit} <= 2'b10;
		step(3'b010, 1'b0);
		check("ddr_out_r", 32'(pad_out), 32'h1);
		step(3'b000, 1'b0);
		check("ddr_out_f", 32'(pad_out), 32'h0);
		// registered enable in bidirectional mode waits for the transmit edge
		wr(8'h00, 32'h0000_0083);
		core_oe <= 1'b1;
		step(3'b000, 1'b0);
		check("oe_wait", 32'(pad_oe_n), 32'h1);
		step(3'b010, 1'b0);
		check("oe_on", 32'(pad_oe_n), 32'h0);
		// clock forwarding, core clock tree high then low
		wr(8'h00, 32'h0000_0004);
		step(3'b001, 1'b0);
		check("clk_hi", 32'(pad_out), 32'h1);
		step(3'b000, 1'b0);
		check("clk_lo", 32'(pad_out), 32'h0);
		// registered output on the falling transmit edge, inverted
		wr(8'h00, 32'h0000_0262);
		rise_launch_bit <= 1'b0;
		step(3'b010, 1'b0);
		check("tx_fall_wait", 32'(pad_out), 32'h0);
		step(3'b000, 1'b0);
		check("tx_fall", 32'(pad_out), 32'h1);
		rd(8'h04, d);
		check("status", d & 32'h0000_0019, 32'h0000_0011);
		config_active <= 1'b1;
		tick(2);
		check("config", {pad_oe_n, pad_pull_up, pad_pull_down}, 32'h6);
		config_active <= 1'b0;
		// reset in mid-run parks the pin again
		resetn <= 1'b0;
		tick(2);
		check("reset_mid", {pad_oe_n, pad_pull_up, pad_pull_down}, 32'h6);
		resetn <= 1'b1;
		// control word width, read-only status and a hole in the map
		wr(8'h00, 32'hffff_ffff);
		rd(8'h00, d);
		check("ctrl", d, 32'h0000_3fff);
		wr(8'h04, 32'h0000_0000);
		rd(8'h00, d);
		check("ctrl_kept", d, 32'h0000_3fff);
		rd(8'h08, d);
		check("unmapped", d, 32'h0000_0000);
		finish_test();
	end
endmodule : configurable_gpio_io_logic_tb

//--- dv/gpio_io_logic_props.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// pin behaviour checks
// ----------------------------------------------------------------
module gpio_io_logic_props
	import gpio_pkg::*;
(
	input wire logic      clk,
	input wire logic      resetn,
	input wire reg_addr_t reg_addr,
	input wire reg_word_t reg_wdata,
	input wire logic      reg_wr,
	input wire logic      reg_rd,
	input wire reg_word_t reg_rdata,
	input wire logic      config_active,
	input wire logic      receive_clock,
	input wire logic      transmit_clock,
	input wire logic      core_clock_tree,
	input wire logic      rise_launch_bit,
	input wire logic      fall_launch_bit,
	input wire logic      core_oe,
	input wire logic      rise_sample_bit,
	input wire logic      fall_sample_bit,
	input wire logic      alternate_input_route,
	input wire logic      pad_in,
	input wire logic      pad_out,
	input wire logic      pad_oe_n,
	input wire logic      pad_pull_up,
	input wire logic      pad_pull_down
);
	logic [13:0] ctrl_q;
	logic [13:0] ctrl_d;
	logic [2:0]  mode;

	// shadow of the control word, so no check has to trust a readback
	always_comb begin
		ctrl_d = ctrl_q;
		if (reg_wr && reg_addr == 8'h00) begin
			ctrl_d = reg_wdata[13:0];
		end
	end
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ctrl_q <= 14'h0000;
		end else begin
			ctrl_q <= ctrl_d;
		end
	end
	assign mode = ctrl_q[2:0];

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	// pad side relations, combinational paths except the forwarded clock, checked every cycle
	a_alt_route_direct: assert property (alternate_input_route == pad_in)
		else $error("alternate route differs from pad");
	a_config_pull_up: assert property (
		config_active |-> pad_pull_up && !pad_pull_down && pad_oe_n)
		else $error("pin not parked during configuration");
	a_pull_exclusive: assert property (!(pad_pull_up && pad_pull_down))
		else $error("both weak pulls on");
	a_drive_no_pull: assert property (
		!pad_oe_n |-> !pad_pull_up && !pad_pull_down && !config_active)
		else $error("pull left on while driving");
	a_idle_pull_level: assert property (
		pad_oe_n && !config_active |-> pad_pull_down == ctrl_q[13] && pad_pull_up == !ctrl_q[13])
		else $error("wrong weak pull while idle");
	a_passive_modes: assert property (!(mode inside {3'h2, 3'h3, 3'h4}) |-> pad_oe_n)
		else $error("driver on in passive mode");
	a_output_drives: assert property (mode == 3'h2 && !config_active |-> !pad_oe_n)
		else $error("driver off in output mode");
	a_output_direct: assert property (
		mode == 3'h2 && !ctrl_q[5] && !ctrl_q[12] && !config_active
		|-> pad_out == (rise_launch_bit ^ ctrl_q[9]))
		else $error("direct output value wrong");
	a_clock_forward: assert property (
		mode == 3'h4 && $past(mode) == 3'h4 && !config_active
		|-> pad_out == $past(core_clock_tree))
		else $error("forwarded clock wrong");
	a_rx_direct: assert property (
		mode == 3'h1 && !ctrl_q[3] && !ctrl_q[10] |-> rise_sample_bit == pad_in)
		else $error("direct input wrong");
	a_fall_bit_idle: assert property (!ctrl_q[10] |-> !fall_sample_bit)
		else $error("fall bit set in single rate");

	c_bidir_drive: cover property (mode == 3'h3 && !pad_oe_n);
	c_ddr_fall: cover property (ctrl_q[10] && fall_sample_bit);
	c_config_hold: cover property (config_active && mode == 3'h4);
endmodule : gpio_io_logic_props

bind gpio_io_logic gpio_io_logic_props u_props (.clk, .resetn, .reg_addr, .reg_wdata,
	.reg_wr, .reg_rd, .reg_rdata, .config_active, .receive_clock, .transmit_clock,
	.core_clock_tree, .rise_launch_bit, .fall_launch_bit, .core_oe, .rise_sample_bit,
	.fall_sample_bit, .alternate_input_route, .pad_in, .pad_out, .pad_oe_n,
	.pad_pull_up, .pad_pull_down);

//--- dv/pad_model.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// board side of the pad
// ----------------------------------------------------------------
module pad_model (
	input  wire logic clk,
	input  wire logic pad_out,
	input  wire logic pad_oe_n,
	input  wire logic pad_pull_up,
	input  wire logic pad_pull_down,
	input  wire logic ext_drive,
	input  wire logic ext_val,
	output logic      pad_in
);
	logic last_q = 1'b0;

	// our driver wins, then the outside driver, then the weak pull;
	// a floating pin flips so a stale value never passes
	always_comb begin
		if (!pad_oe_n) begin
			pad_in = pad_out;
		end else if (ext_drive) begin
			pad_in = ext_val;
		end else if (pad_pull_up || pad_pull_down) begin
			pad_in = pad_pull_up;
		end else begin
			pad_in = ~last_q;
		end
	end
	always_ff @(posedge clk) begin
		last_q <= pad_in;
	end
endmodule : pad_model

//--- hw/gpio_edge_detect.sv
`timescale 1ns/100ps
// turns a sampled core clock into one-cycle rise and fall enable pulses
module gpio_edge_detect
	import gpio_pkg::*;
(
	input  wire logic   clk,
	input  wire logic   resetn,
	input  wire logic   clk_sample,
	gpio_edge_if.src    edge_o
);
	logic prev_q;
	logic prev_d;

	// ------------------------------------------------------------------------
	// previous level
	// ------------------------------------------------------------------------
	// one cycle of history is enough: the sample is synchronous to clk
	always_comb begin
		prev_d = clk_sample;
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			prev_q <= 1'b0;
		end else begin
			prev_q <= prev_d;
		end
	end

	// pulses last exactly one clk cycle
	assign edge_o.level = clk_sample;
	assign edge_o.rise  = clk_sample & ~prev_q;
	assign edge_o.fall  = ~clk_sample & prev_q;

endmodule : gpio_edge_detect

//--- hw/gpio_io_logic.sv
`timescale 1ns/100ps
`include "gpio_cfg.svh"
// per-pin i/o logic between core fabric and pad
module gpio_io_logic
	import gpio_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       resetn,
	// register port
	input  wire reg_addr_t  reg_addr,
	input  wire reg_word_t  reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output reg_word_t       reg_rdata,
	// device state
	input  wire logic       config_active,
	// core fabric
	input  wire logic       receive_clock,
	input  wire logic       transmit_clock,
	input  wire logic       core_clock_tree,
	input  wire logic       rise_launch_bit,
	input  wire logic       fall_launch_bit,
	input  wire logic       core_oe,
	output logic            rise_sample_bit,
	output logic            fall_sample_bit,
	output logic            alternate_input_route,
	// pad
	input  wire logic       pad_in,
	output logic            pad_out,
	output logic            pad_oe_n,
	output logic            pad_pull_up,
	output logic            pad_pull_down
);

	// ------------------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------------------
	reg_word_t  ctrl_q, ctrl_d;
	reg_word_t  rdata_q, rdata_d;
	logic       tx_q, tx_d;
	logic       oe_q, oe_d;
	logic       ck_q, ck_d;
	gpio_mode_t mode;
	logic       rx_on;
	logic       tx_on;
	logic       ck_on;
	logic       tx_val;
	logic       oe_val;
	logic       drive;
	logic       rx_rise_flop;
	logic       rx_fall_flop;

	gpio_edge_if rx_e ();
	gpio_edge_if tx_e ();

	// ------------------------------------------------------------------------
	// control field decode
	// ------------------------------------------------------------------------
	// codes above the last mode fall back to unused, so the pin stays quiet
	always_comb begin
		case (ctrl_q[`CTRL_MODE_MSB:`CTRL_MODE_LSB])
			3'h1: mode = MODE_INPUT;
			3'h2: mode = MODE_OUTPUT;
			3'h3: mode = MODE_BIDIR;
			3'h4: mode = MODE_CLKOUT;
			default: mode = MODE_UNUSED;
		endcase
	end

	// path enables per mode
	always_comb begin
		rx_on = 1'b0;
		tx_on = 1'b0;
		ck_on = 1'b0;
		case (mode)
			MODE_INPUT: begin
				rx_on = 1'b1;
			end
			MODE_OUTPUT: begin
				tx_on = 1'b1;
			end
			MODE_BIDIR: begin
				rx_on = 1'b1;
				tx_on = 1'b1;
			end
			MODE_CLKOUT: begin
				ck_on = 1'b1;
			end
			default: begin
				rx_on = 1'b0;
			end
		endcase
	end

	// ------------------------------------------------------------------------
	// clock edge pulses
	// ------------------------------------------------------------------------
	// both core clocks are sampled on clk, so they must run well below 12.5 MHz
	gpio_edge_detect u_rx_edges (
		.clk        (clk),
		.resetn     (resetn),
		.clk_sample (receive_clock),
		.edge_o     (rx_e)
	);

	gpio_edge_detect u_tx_edges (
		.clk        (clk),
		.resetn     (resetn),
		.clk_sample (transmit_clock),
		.edge_o     (tx_e)
	);

	// ------------------------------------------------------------------------
	// receive path
	// ------------------------------------------------------------------------
	gpio_rx_path u_rx (
		.clk             (clk),
		.resetn          (resetn),
		.rx_e            (rx_e),
		.pad_in          (pad_in),
		.rx_on           (rx_on),
		.rx_reg          (ctrl_q[`CTRL_RX_REG]),
		.rx_edge         (ctrl_q[`CTRL_RX_EDGE]),
		.ddr_in          (ctrl_q[`CTRL_DDR_IN]),
		.resync          (ctrl_q[`CTRL_RESYNC]),
		.rise_sample_bit (rise_sample_bit),
		.fall_sample_bit (fall_sample_bit),
		.rise_flop       (rx_rise_flop),
		.fall_flop       (rx_fall_flop)
	);

	// alternate route skips every flop; it feeds a reference input, not the core
	assign alternate_input_route = pad_in;

	// ------------------------------------------------------------------------
	// transmit, enable and clock forward flops
	// ------------------------------------------------------------------------
	// double rate output reuses the single data flop as the edge multiplexer
	always_comb begin
		tx_d = tx_q;
		oe_d = oe_q;
		ck_d = core_clock_tree;
		if (ctrl_q[`CTRL_DDR_OUT]) begin
			if (tx_e.rise) begin
				tx_d = rise_launch_bit;
			end else if (tx_e.fall) begin
				tx_d = fall_launch_bit;
			end
		end else if (pick_edge(ctrl_q[`CTRL_TX_EDGE], tx_e.rise, tx_e.fall)) begin
			tx_d = rise_launch_bit;
		end
		if (pick_edge(ctrl_q[`CTRL_OE_EDGE], tx_e.rise, tx_e.fall)) begin
			oe_d = core_oe;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			tx_q <= 1'b0;
			oe_q <= 1'b0;
			ck_q <= 1'b0;
		end else begin
			tx_q <= tx_d;
			oe_q <= oe_d;
			ck_q <= ck_d;
		end
	end

	// ------------------------------------------------------------------------
	// pad drive
	// ------------------------------------------------------------------------
	// transmit registering is independent of the receive choice
	always_comb begin
		tx_val = rise_launch_bit;
		if (ctrl_q[`CTRL_TX_REG] || ctrl_q[`CTRL_DDR_OUT]) begin
			tx_val = tx_q;
		end
		tx_val = tx_val ^ ctrl_q[`CTRL_INVERT];
	end

	// enable: output mode always drives, bidir follows the core enable
	always_comb begin
		oe_val = 1'b0;
		if (mode == MODE_OUTPUT || ck_on) begin
			oe_val = 1'b1;
		end else if (mode == MODE_BIDIR) begin
			oe_val = ctrl_q[`CTRL_OE_REG] ? oe_q : core_oe;
		end
	end

	// configuration overrides everything: driver off, pull-up only
	always_comb begin
		drive         = oe_val & ~config_active;
		pad_oe_n      = ~drive;
		pad_out       = 1'b0;
		pad_pull_up   = 1'b0;
		pad_pull_down = 1'b0;
		if (drive) begin
			pad_out = ck_on ? ck_q : tx_val;
		end
		if (config_active) begin
			pad_pull_up = 1'b1;
		end else if (!drive) begin
			pad_pull_up   = ~ctrl_q[`CTRL_PULL_DOWN];
			pad_pull_down = ctrl_q[`CTRL_PULL_DOWN];
		end
	end

	// ------------------------------------------------------------------------
	// register port
	// ------------------------------------------------------------------------
	// read data stand for one cycle only, zero otherwise and for unmapped reads
	always_comb begin
		ctrl_d  = ctrl_q;
		rdata_d = '0;
		if (reg_wr && reg_addr == `REG_CTRL_OFS) begin
			ctrl_d = '0;
			ctrl_d[`CTRL_USED_MSB:0] = reg_wdata[`CTRL_USED_MSB:0];
		end
		if (reg_rd) begin
			if (reg_addr == `REG_CTRL_OFS) begin
				rdata_d = ctrl_q;
			end else if (reg_addr == `REG_STATUS_OFS) begin
				rdata_d[`STAT_PAD_IN]  = pad_in;
				rdata_d[`STAT_RX_RISE] = rx_rise_flop;
				rdata_d[`STAT_RX_FALL] = rx_fall_flop;
				rdata_d[`STAT_TX_VAL]  = tx_q;
				rdata_d[`STAT_DRIVING] = drive;
				rdata_d[`STAT_CONFIG]  = config_active;
			end
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ctrl_q  <= `CTRL_RESET;
			rdata_q <= '0;
		end else begin
			ctrl_q  <= ctrl_d;
			rdata_q <= rdata_d;
		end
	end

	assign reg_rdata = rdata_q;

endmodule : gpio_io_logic

//--- hw/gpio_rx_path.sv
`timescale 1ns/100ps
// receive side: direct, single edge registered, or double rate capture
module gpio_rx_path
	import gpio_pkg::*;
(
	input  wire logic   clk,
	input  wire logic   resetn,
	gpio_edge_if.dst    rx_e,
	input  wire logic   pad_in,
	input  wire logic   rx_on,
	input  wire logic   rx_reg,
	input  wire logic   rx_edge,
	input  wire logic   ddr_in,
	input  wire logic   resync,
	output logic        rise_sample_bit,
	output logic        fall_sample_bit,
	output logic        rise_flop,
	output logic        fall_flop
);
	logic rx_q, rx_d;
	logic rise_q, rise_d;
	logic fall_q, fall_d;
	logic fall_rs_q, fall_rs_d;

	// ------------------------------------------------------------------------
	// capture flops
	// ------------------------------------------------------------------------
	always_comb begin
		rx_d      = rx_q;
		rise_d    = rise_q;
		fall_d    = fall_q;
		fall_rs_d = fall_rs_q;
		if (pick_edge(rx_edge, rx_e.rise, rx_e.fall)) begin
			rx_d = pad_in;
		end
		if (rx_e.rise) begin
			rise_d    = pad_in;
			fall_rs_d = fall_q;
		end
		if (rx_e.fall) begin
			fall_d = pad_in;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rx_q      <= 1'b0;
			rise_q    <= 1'b0;
			fall_q    <= 1'b0;
			fall_rs_q <= 1'b0;
		end else begin
			rx_q      <= rx_d;
			rise_q    <= rise_d;
			fall_q    <= fall_d;
			fall_rs_q <= fall_rs_d;
		end
	end

	// ------------------------------------------------------------------------
	// core-facing bits
	// ------------------------------------------------------------------------
	// the unregistered choice is a plain wire from the pad, so it has no latency
	always_comb begin
		rise_sample_bit = 1'b0;
		fall_sample_bit = 1'b0;
		if (rx_on) begin
			if (ddr_in) begin
				rise_sample_bit = rise_q;
				fall_sample_bit = resync ? fall_rs_q : fall_q;
			end else begin
				rise_sample_bit = rx_reg ? rx_q : pad_in;
			end
		end
	end

	assign rise_flop = rise_q;
	assign fall_flop = fall_q;

endmodule : gpio_rx_path

//--- include/gpio_cfg.svh
// Operation
// - input mode: receive path only, direct or registered on chosen receive clock edge
// - alternate input route comes straight from the pad, never registered
// - double rate input: one flop per receive clock edge, two bits to core
// - output mode: transmit path only, direct or registered on chosen transmit edge
// - output and bidirectional modes may invert the output value toward the pad
// - double rate output: flops per transmit edge, multiplexed onto one pad stream; here one data flop is reloaded on each transmit edge
// - bidirectional: receive, transmit and enable active, each on its own clock edge
// - receive registering chosen independently of transmit registering
// - output enable switches pad driver, optionally registered with transmit data
// - input register captures pad, output register holds core data for pad
// - clock output mode forwards core clock tree clock to the pad instead of data
// - during configuration every pin weak pull-up with driver off
// - in user operation an unused pin is tristated with weak pull-up
// - unused pin pull may be switched to weak pull-down by a setting
// - double rate input: bit 0 rising sample, bit 1 falling; single rate bit 0
// - double rate output: bit 0 on rising edge, bit 1 on falling; single rate bit 0
// - resync variant delays falling sample half a cycle, both bits at rising edge
`ifndef GPIO_CFG_SVH
`define GPIO_CFG_SVH

// ----------------------------------------------------------------------------
// register map
// ----------------------------------------------------------------------------
`define REG_CTRL_OFS        8'h00
`define REG_STATUS_OFS      8'h04
`define CTRL_RESET          32'h0000_0000

// ----------------------------------------------------------------------------
// control field positions
// ----------------------------------------------------------------------------
`define CTRL_MODE_LSB       0
`define CTRL_MODE_MSB       2
`define CTRL_RX_REG         3
`define CTRL_RX_EDGE        4
`define CTRL_TX_REG         5
`define CTRL_TX_EDGE        6
`define CTRL_OE_REG         7
`define CTRL_OE_EDGE        8
`define CTRL_INVERT         9
`define CTRL_DDR_IN         10
`define CTRL_RESYNC         11
`define CTRL_DDR_OUT        12
`define CTRL_PULL_DOWN      13
`define CTRL_USED_MSB       13

// ----------------------------------------------------------------------------
// status field positions
// ----------------------------------------------------------------------------
`define STAT_PAD_IN         0
`define STAT_RX_RISE        1
`define STAT_RX_FALL        2
`define STAT_TX_VAL         3
`define STAT_DRIVING        4
`define STAT_CONFIG         5
`define STAT_USED_MSB       5

`endif

//--- include/gpio_edge_if.sv
`timescale 1ns/100ps
// edge pulses of one sampled core clock, carried between modules
interface gpio_edge_if;
	logic level;
	logic rise;
	logic fall;

	modport src (output level, output rise, output fall);
	modport dst (input level, input rise, input fall);
endinterface : gpio_edge_if

//--- include/gpio_pkg.sv
package gpio_pkg;

	// pin mode, encoded in the low bits of the control register
	typedef enum logic [2:0] {
		MODE_UNUSED,
		MODE_INPUT,
		MODE_OUTPUT,
		MODE_BIDIR,
		MODE_CLKOUT
	} gpio_mode_t;

	typedef logic [7:0]  reg_addr_t;
	typedef logic [31:0] reg_word_t;

	// pick the enable pulse of the selected edge: 0 rising, 1 falling
	function automatic logic pick_edge(input logic fall_sel, input logic rise,
		input logic fall);
		return fall_sel ? fall : rise;
	endfunction : pick_edge

endpackage : gpio_pkg
